// >>> inc/tah_consts.vh
// Constants for the trigger/acquisition opcode interpreter
// Notes on behaviour
// - Trigger-match opcode also enables reject and keep-token
// - Continuous opcode also clears reject and subtraction
// - Read-mode returns one word, bit0 mode
// - Wait until every expected data word moves
// - Keep-token set: converter drains whole event
// - Keep-token clear: one word per token pass
// - Load-default applies documented default settings
// - At reset apply default or saved per flag
// - Save-user stores mode, window, margins, channels
// - Load-user restores the saved configuration
// - Two opcodes set and clear auto-load flag
// - Width takes bits 11:0, default 0x14
// - Offset is sign-extended 12-bit, default 0xFFD8; all 16 bits are taken as written
// - Window start aligned to sampling clock
// - Search margin 12 bits, upper ignored, default 0x08
// - Reject margin 12 bits, default 0x04
// - Subtraction on: times relative to window start
// - Subtraction off: times relative to bunch reset
// - Read-trigger returns five words in order
// - Error-status read returns converter's 11 bits
// - Setup readback returns 41 words of chain
// - Marked opcodes request converter reprogramming
`ifndef TAH_CONSTS_VH
`define TAH_CONSTS_VH
`define TAH_OP_TRIG_MODE 8'h00
`define TAH_OP_CONT_MODE 8'h01
`define TAH_OP_READ_MODE 8'h02
`define TAH_OP_KEEP_SET 8'h03
`define TAH_OP_KEEP_CLR 8'h04
`define TAH_OP_LOAD_DEF 8'h05
`define TAH_OP_SAVE_USER 8'h06
`define TAH_OP_LOAD_USER 8'h07
`define TAH_OP_AUTO_USER 8'h08
`define TAH_OP_AUTO_DEF 8'h09
`define TAH_OP_WIN_WIDTH 8'h10
`define TAH_OP_WIN_OFFS 8'h11
`define TAH_OP_SRCH_MARGIN 8'h12
`define TAH_OP_REJ_MARGIN 8'h13
`define TAH_OP_SUB_EN 8'h14
`define TAH_OP_SUB_DIS 8'h15
`define TAH_OP_READ_TRIG 8'h16
`define TAH_OP_ERR_STATUS 8'h74
`define TAH_OP_CHAIN_READ 8'hC9
`define TAH_DEF_WIDTH 12'h014
`define TAH_DEF_OFFSET 16'hFFD8
`define TAH_DEF_SRCH 12'h008
`define TAH_DEF_REJ 12'h004
`define TAH_DEF_CHAN 32'hFFFFFFFF
`define TAH_TRIG_WORDS 4'h5
`define TAH_CHAIN_WORDS 6'h29
`define TAH_CHAIN_BITS 646
`define TAH_ERR_BITS 11
`endif

// >>> hdl/tah_word_seq.v
// Counter that paces a multi-word transfer with the host
module tah_word_seq
(
	core_clk,
	reset,
	start,
	count,
	step,
	busy,
	index
);
	input wire core_clk; // System clock
	input wire reset; // Synchronous reset
	input wire start; // Load a new transfer
	input wire [5:0] count; // Words expected
	input wire step; // One word moved
	output wire busy; // Transfer in progress
	output wire [5:0] index; // Current word number

	reg [5:0] left_ff; // Words still to move
	reg [5:0] idx_ff; // Word number
	reg [5:0] nxt_left;
	reg [5:0] nxt_idx;

	assign busy = (left_ff != 6'h00);
	assign index = idx_ff;

	// Next state: stall until every word moved
	always @*
	begin
		nxt_left = left_ff;
		nxt_idx = idx_ff;
		if (start)
		begin
			nxt_left = count;
			nxt_idx = 6'h00;
		end
		else if (step && busy)
		begin
			nxt_left = left_ff - 6'h01;
			nxt_idx = idx_ff + 6'h01;
		end
	end

	// Registers
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			left_ff <= 6'h00;
			idx_ff <= 6'h00;
		end
		else
		begin
			left_ff <= nxt_left;
			idx_ff <= nxt_idx;
		end
	end
endmodule // tah_word_seq

// >>> hdl/tah_opcode_handler.v
// Opcode interpreter for acquisition and trigger settings
`include "tah_consts.vh"
module tah_opcode_handler
#(
	parameter NCONV = 4 // Number of converters
)
(
	input wire core_clk,
	input wire reset,
	input wire cmd_wr,
	input wire cmd_rd,
	input wire [15:0] cmd_wdata,
	output reg [15:0] cmd_rdata,
	output wire cmd_busy,
	input wire [NCONV*`TAH_ERR_BITS-1:0] conv_err_bits,
	input wire [NCONV*`TAH_CHAIN_BITS-1:0] conv_chain_bits,
	input wire [95:0] nv_user_cfg,
	input wire nv_auto_load,
	output reg nv_store,
	output reg [95:0] nv_store_cfg,
	output reg nv_auto_store,
	output reg nv_auto_value,
	output reg trig_match_ff,
	output reg auto_reject_ff,
	output reg keep_token_ff,
	output reg trig_sub_ff,
	output reg [11:0] win_width_ff,
	output reg [15:0] win_offset_ff,
	output reg [11:0] srch_margin_ff,
	output reg [11:0] rej_margin_ff,
	output reg [31:0] chan_enable_ff,
	output reg reprog_setup
);
	// Interpreter states
	localparam ST_RESET = 2'h0;
	localparam ST_IDLE = 2'h1;
	localparam ST_WRITE = 2'h2;
	localparam ST_READ = 2'h3;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [7:0] op_ff; // Command held during data phase
	reg [7:0] idx_ff; // Lower byte of opcode
	reg seq_start;
	reg [5:0] seq_count;
	wire seq_busy;
	wire [5:0] seq_index;
	wire [7:0] op_code;
	wire [7:0] op_index;

	// Pin-side strobes pass two flip-flops before use
	reg [1:0] wr_sync_ff;
	reg [1:0] rd_sync_ff;
	reg wr_seen_ff;
	reg rd_seen_ff;
	reg wr_dly_ff; // Write edge memory one stage later, so the pulse meets the captured word
	reg [15:0] wdata_ff;
	wire wr_pulse;
	wire rd_pulse;

	assign op_code = wdata_ff[15:8];
	assign op_index = wdata_ff[7:0];
	assign wr_pulse = wr_seen_ff & ~wr_dly_ff;
	assign rd_pulse = rd_sync_ff[1] & ~rd_seen_ff;
	assign cmd_busy = (state_ff == ST_WRITE) || (state_ff == ST_READ);

	// Chain readback word: 16 bits from the selected converter
	function [15:0] tah_chain_word;
		input [NCONV*`TAH_CHAIN_BITS-1:0] chains;
		input [7:0] conv;
		input [5:0] word;
		integer b;
		integer pos;
		begin
			tah_chain_word = 16'h0000;
			for (b = 0; b < 16; b = b + 1)
			begin
				pos = word * 16 + b;
				if (pos < `TAH_CHAIN_BITS && conv < NCONV)
					tah_chain_word[b] = chains[conv * `TAH_CHAIN_BITS + pos];
			end
		end
	endfunction

	// Error bits of one converter
	function [15:0] tah_err_word;
		input [NCONV*`TAH_ERR_BITS-1:0] errs;
		input [7:0] conv;
		integer b;
		begin
			tah_err_word = 16'h0000;
			for (b = 0; b < `TAH_ERR_BITS; b = b + 1)
				if (conv < NCONV)
					tah_err_word[b] = errs[conv * `TAH_ERR_BITS + b];
		end
	endfunction

	tah_word_seq u_seq
	(
		.core_clk(core_clk),
		.reset(reset),
		.start(seq_start),
		.count(seq_count),
		.step((state_ff == ST_WRITE) ? wr_pulse : rd_pulse),
		.busy(seq_busy),
		.index(seq_index)
	);

	// Input synchronisers and edge memory
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			wr_sync_ff <= 2'b00;
			rd_sync_ff <= 2'b00;
			wr_seen_ff <= 1'b0;
			rd_seen_ff <= 1'b0;
			wr_dly_ff <= 1'b0;
			wdata_ff <= 16'h0000;
		end
		else
		begin
			wr_sync_ff <= {wr_sync_ff[0], cmd_wr};
			rd_sync_ff <= {rd_sync_ff[0], cmd_rd};
			wr_seen_ff <= wr_sync_ff[1];
			rd_seen_ff <= rd_sync_ff[1];
			wr_dly_ff <= wr_seen_ff;
			// Capture once at the strobe's rising edge; the host may release data before the sync drains
			if (wr_sync_ff[1] && !wr_seen_ff)
				wdata_ff <= cmd_wdata;
		end
	end

	// Decide transfer length from the opcode
	always @*
	begin
		seq_start = 1'b0;
		seq_count = 6'h00;
		if (state_ff == ST_IDLE && wr_pulse)
		begin
			case (op_code)
				`TAH_OP_READ_MODE, `TAH_OP_ERR_STATUS:
				begin
					seq_start = 1'b1;
					seq_count = 6'h01;
				end
				`TAH_OP_WIN_WIDTH, `TAH_OP_WIN_OFFS, `TAH_OP_SRCH_MARGIN, `TAH_OP_REJ_MARGIN:
				begin
					seq_start = 1'b1;
					seq_count = 6'h01;
				end
				`TAH_OP_READ_TRIG:
				begin
					seq_start = 1'b1;
					seq_count = {2'b00, `TAH_TRIG_WORDS};
				end
				`TAH_OP_CHAIN_READ:
				begin
					seq_start = 1'b1;
					seq_count = `TAH_CHAIN_WORDS;
				end
				default:
				begin
					seq_start = 1'b0;
					seq_count = 6'h00;
				end
			endcase
		end
	end

	// State sequencing
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET:
				nxt_state = ST_IDLE;
			ST_IDLE:
				if (seq_start)
				begin
					if (op_code == `TAH_OP_WIN_WIDTH || op_code == `TAH_OP_WIN_OFFS ||
						op_code == `TAH_OP_SRCH_MARGIN || op_code == `TAH_OP_REJ_MARGIN)
						nxt_state = ST_WRITE;
					else
						nxt_state = ST_READ;
				end
			ST_WRITE, ST_READ:
				// Leave only after the last word moved
				if (!seq_busy && !seq_start)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// Read data presented to the host for the current word
	always @(posedge core_clk)
	begin
		if (reset)
			cmd_rdata <= 16'h0000;
		else
		begin
			case (op_ff)
				`TAH_OP_READ_MODE:
					cmd_rdata <= {15'h0000, trig_match_ff};
				`TAH_OP_READ_TRIG:
					case (seq_index)
						6'h00: cmd_rdata <= {4'h0, win_width_ff};
						6'h01: cmd_rdata <= win_offset_ff;
						6'h02: cmd_rdata <= {4'h0, srch_margin_ff};
						6'h03: cmd_rdata <= {4'h0, rej_margin_ff};
						default: cmd_rdata <= {15'h0000, trig_sub_ff};
					endcase
				`TAH_OP_ERR_STATUS:
					cmd_rdata <= tah_err_word(conv_err_bits, idx_ff);
				`TAH_OP_CHAIN_READ:
					cmd_rdata <= tah_chain_word(conv_chain_bits, idx_ff, seq_index);
				default:
					cmd_rdata <= 16'h0000;
			endcase
		end
	end

	// Configuration registers and opcode effects
	always @(posedge core_clk)
	begin
		nv_store <= 1'b0;
		nv_auto_store <= 1'b0;
		reprog_setup <= 1'b0;
		if (reset)
		begin
			state_ff <= ST_RESET;
			op_ff <= 8'h00;
			idx_ff <= 8'h00;
			nv_store_cfg <= 96'h0;
			nv_auto_value <= 1'b0;
			trig_match_ff <= 1'b0;
			auto_reject_ff <= 1'b0;
			keep_token_ff <= 1'b0;
			trig_sub_ff <= 1'b0;
			win_width_ff <= `TAH_DEF_WIDTH;
			win_offset_ff <= `TAH_DEF_OFFSET;
			srch_margin_ff <= `TAH_DEF_SRCH;
			rej_margin_ff <= `TAH_DEF_REJ;
			chan_enable_ff <= `TAH_DEF_CHAN;
		end
		else
		begin
			state_ff <= nxt_state;
			// Auto-load flag is sampled once after reset release
			if (state_ff == ST_RESET && nv_auto_load)
			begin
				{trig_match_ff, win_width_ff, win_offset_ff, srch_margin_ff} <= nv_user_cfg[56:16];
				rej_margin_ff <= nv_user_cfg[15:4];
				chan_enable_ff <= nv_user_cfg[95:64];
				reprog_setup <= 1'b1;
			end
			if (state_ff == ST_IDLE && wr_pulse)
			begin
				op_ff <= op_code;
				idx_ff <= op_index;
				case (op_code)
					`TAH_OP_TRIG_MODE:
					begin
						trig_match_ff <= 1'b1;
						auto_reject_ff <= 1'b1;
						keep_token_ff <= 1'b1;
						reprog_setup <= 1'b1;
					end
					`TAH_OP_CONT_MODE:
					begin
						trig_match_ff <= 1'b0;
						auto_reject_ff <= 1'b0;
						trig_sub_ff <= 1'b0;
						reprog_setup <= 1'b1;
					end
					// Converters drain a full event per token, or one word
					`TAH_OP_KEEP_SET:
						keep_token_ff <= 1'b1;
					`TAH_OP_KEEP_CLR:
						keep_token_ff <= 1'b0;
					`TAH_OP_LOAD_DEF:
					begin
						trig_match_ff <= 1'b0;
						win_width_ff <= `TAH_DEF_WIDTH;
						win_offset_ff <= `TAH_DEF_OFFSET;
						rej_margin_ff <= `TAH_DEF_REJ;
						srch_margin_ff <= `TAH_DEF_SRCH;
						chan_enable_ff <= `TAH_DEF_CHAN;
						reprog_setup <= 1'b1;
					end
					`TAH_OP_SAVE_USER:
					begin
						// Same layout the power-up restore reads back
						nv_store_cfg <= {chan_enable_ff, 7'h00, trig_match_ff, win_width_ff, win_offset_ff,
							srch_margin_ff, rej_margin_ff, 4'h0};
						nv_store <= 1'b1;
					end
					`TAH_OP_LOAD_USER:
					begin
						{trig_match_ff, win_width_ff, win_offset_ff, srch_margin_ff} <= nv_user_cfg[56:16];
						rej_margin_ff <= nv_user_cfg[15:4];
						chan_enable_ff <= nv_user_cfg[95:64];
						reprog_setup <= 1'b1;
					end
					`TAH_OP_AUTO_USER:
					begin
						nv_auto_value <= 1'b1;
						nv_auto_store <= 1'b1;
					end
					`TAH_OP_AUTO_DEF:
					begin
						nv_auto_value <= 1'b0;
						nv_auto_store <= 1'b1;
					end
					// Hit times referenced to window start or bunch reset
					`TAH_OP_SUB_EN:
					begin
						trig_sub_ff <= 1'b1;
						reprog_setup <= 1'b1;
					end
					`TAH_OP_SUB_DIS:
					begin
						trig_sub_ff <= 1'b0;
						reprog_setup <= 1'b1;
					end
					default:
						reprog_setup <= 1'b0;
				endcase
			end
			// Data word of a setting opcode; window start is clock-aligned by count
			if (state_ff == ST_WRITE && wr_pulse && seq_busy)
			begin
				reprog_setup <= 1'b1;
				case (op_ff)
					`TAH_OP_WIN_WIDTH:
						win_width_ff <= wdata_ff[11:0];
					`TAH_OP_WIN_OFFS:
						win_offset_ff <= wdata_ff;
					`TAH_OP_SRCH_MARGIN:
						srch_margin_ff <= wdata_ff[11:0];
					`TAH_OP_REJ_MARGIN:
						rej_margin_ff <= wdata_ff[11:0];
					default:
						reprog_setup <= 1'b0;
				endcase
			end
		end
	end
endmodule // tah_opcode_handler

// >>> dv/tah_opcode_handler_props.sv
// Port-level assertions for the opcode interpreter
module tah_handler_props
#(
	parameter NCONV = 4 // Converter count, handed on from the design
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic cmd_busy,
	input wire logic nv_store,
	input wire logic [95:0] nv_store_cfg,
	input wire logic nv_auto_store,
	input wire logic trig_match_ff,
	input wire logic [11:0] win_width_ff,
	input wire logic [15:0] win_offset_ff,
	input wire logic [11:0] srch_margin_ff,
	input wire logic [11:0] rej_margin_ff,
	input wire logic [31:0] chan_enable_ff,
	input wire logic reprog_setup
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Reset itself is the cause here, so this one is never disabled
	AST_RESET_DEFAULTS: assert property (disable iff (1'b0) reset |=> win_width_ff == 12'h014 && !trig_match_ff
		&& win_offset_ff == 16'hFFD8 && srch_margin_ff == 12'h008 && rej_margin_ff == 12'h004
		&& chan_enable_ff == 32'hFFFFFFFF) else $error("config not at defaults after reset");
	AST_STORE_IMAGE: assert property (nv_store |-> nv_store_cfg[55:44] == win_width_ff
		&& nv_store_cfg[43:28] == win_offset_ff && nv_store_cfg[27:16] == srch_margin_ff
		&& nv_store_cfg[15:4] == rej_margin_ff && nv_store_cfg[95:64] == chan_enable_ff
		&& nv_store_cfg[56] == trig_match_ff) else $error("stored image differs from live config");
	AST_STORE_PULSE: assert property (nv_store |=> !nv_store) else $error("store strobe longer than a cycle");
	AST_AUTO_PULSE: assert property (nv_auto_store |=> !nv_auto_store) else $error("flag store strobe too long");
	AST_BUSY_HOLD: assert property ((!cmd_wr && !cmd_rd)[*6] ##0 cmd_busy |=> cmd_busy)
		else $error("busy dropped with no host transfer");
	AST_BUSY_CAUSE: assert property ($rose(cmd_busy) |-> $past(cmd_wr, 3) || $past(cmd_wr, 4) || $past(cmd_wr, 5))
		else $error("busy rose without a host write");
	AST_REPROG: assert property ($changed(win_width_ff) && !$past(reset) |-> (##[0:3] reprog_setup)
		or $past(reprog_setup)) else $error("width changed without reprogramming");
	// Settings only move in answer to a host transfer or the auto-load restore after reset
	AST_IDLE_STABLE: assert property ((!cmd_wr && !cmd_rd)[*8] |=> $stable(win_width_ff) && $stable(trig_match_ff))
		else $error("config moved while host idle");
endmodule // tah_handler_props
bind tah_opcode_handler tah_handler_props #(.NCONV(NCONV)) tah_handler_props_inst (.core_clk, .reset, .cmd_wr,
	.cmd_rd, .cmd_busy, .nv_store, .nv_store_cfg, .nv_auto_store, .trig_match_ff, .win_width_ff, .win_offset_ff,
	.srch_margin_ff, .rej_margin_ff, .chan_enable_ff, .reprog_setup);

// >>> dv/tah_host_bfm.sv
// Host model writing opcodes and data words and reading answers
module tah_host_bfm
(
	input wire logic core_clk,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle strobes at time zero
	initial
	begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_wdata = 16'hA5C3;
	end
	// Strobes stay high 4 cycles and low 6; released data is inverted so it never looks valid
	task automatic wr(input logic [15:0] w);
		@(negedge core_clk);
		cmd_wdata = w;
		cmd_wr = 1'b1;
		repeat (4) @(negedge core_clk);
		cmd_wr = 1'b0;
		cmd_wdata = ~w;
		repeat (6) @(negedge core_clk);
	endtask
	// Word is taken before the strobe moves the interpreter on
	task automatic rd(output logic [15:0] r);
		@(negedge core_clk);
		r = cmd_rdata;
		cmd_rd = 1'b1;
		repeat (4) @(negedge core_clk);
		cmd_rd = 1'b0;
		repeat (6) @(negedge core_clk);
	endtask
endmodule // tah_host_bfm

// >>> dv/tb.sv
// Self-checking bench for the opcode interpreter
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam NC = 4; // Converters in this build
	logic core_clk, reset, cmd_wr, cmd_rd, cmd_busy, nv_store, nv_auto_store, nv_auto_value, nv_auto_load;
	logic reprog_setup, trig_match_ff, auto_reject_ff, keep_token_ff, trig_sub_ff;
	logic [15:0] cmd_wdata, cmd_rdata, win_offset_ff, r;
	logic [11:0] win_width_ff, srch_margin_ff, rej_margin_ff;
	logic [31:0] chan_enable_ff;
	logic [95:0] nv_user_cfg, nv_store_cfg;
	logic [NC*11-1:0] conv_err_bits;
	logic [NC*646-1:0] conv_chain_bits;
	logic [63:0] d; // Four data words of one round
	logic [3:0] f; // Expected mode, reject, keep, subtract
	logic [15:0] cfg [0:3]; // Expected width, offset, search, reject
	logic [15:0] u [0:3]; // Image expected back from the store
	logic [15:0] dflt [0:3] = '{16'h0014, 16'hFFD8, 16'h0008, 16'h0004};
	logic [7:0] mops [0:8] = '{8'h14, 8'h01, 8'h03, 8'h04, 8'h00, 8'h15, 8'h04, 8'h01, 8'h00};
	int n_fail = 0;
	int total_checks = 0;
	tah_opcode_handler #(.NCONV(NC)) tah_opcode_handler_inst (.core_clk, .reset, .cmd_wr, .cmd_rd, .cmd_wdata,
		.cmd_rdata, .cmd_busy, .conv_err_bits, .conv_chain_bits, .nv_user_cfg, .nv_auto_load, .nv_store,
		.nv_store_cfg, .nv_auto_store, .nv_auto_value, .trig_match_ff, .auto_reject_ff, .keep_token_ff,
		.trig_sub_ff, .win_width_ff, .win_offset_ff, .srch_margin_ff, .rej_margin_ff, .chan_enable_ff, .reprog_setup);
	tah_host_bfm tah_host_bfm_inst (.core_clk, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata);
	// 250 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Nonvolatile stand-in keeps what the interpreter saves
	always @(negedge core_clk)
	begin
		if (nv_store === 1'b1)
			nv_user_cfg <= nv_store_cfg;
		if (nv_auto_store === 1'b1)
			nv_auto_load <= nv_auto_value;
	end
	// Flag update expected for each mode opcode
	function automatic logic [3:0] exp_flags(input logic [7:0] op, input logic [3:0] v);
		case (op)
			8'h00: return v | 4'hE;
			8'h01: return v & 4'h2;
			8'h03: return v | 4'h2;
			8'h04: return v & 4'hD;
			8'h14: return v | 4'h1;
			default: return v & 4'hE;
		endcase
	endfunction
	// Offset is kept whole, the other words keep twelve bits
	function automatic logic [15:0] exp_word(input int i, input logic [15:0] w);
		return (i == 1) ? w : {4'h0, w[11:0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cfg_chk;
		chk({4'h0, win_width_ff}, cfg[0]);
		chk(win_offset_ff, cfg[1]);
		chk({4'h0, srch_margin_ff}, cfg[2]);
		chk({4'h0, rej_margin_ff}, cfg[3]);
	endtask
	// Opcode with a random index byte, which these commands ignore
	task automatic send(input logic [7:0] c);
		tah_host_bfm_inst.wr({c, 8'($urandom)});
	endtask
	task automatic do_reset;
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(32'h04A5A5DF));
		nv_auto_load = 1'b0;
		nv_user_cfg = 96'h0;
		f = 4'h0;
		repeat (81) conv_chain_bits = {conv_chain_bits[NC*646-33:0], $urandom};
		repeat (2) conv_err_bits = {conv_err_bits[NC*11-33:0], $urandom};
		do_reset;
		cfg = dflt;
		cfg_chk;
		chk(chan_enable_ff[15:0], 16'hFFFF);
		foreach (mops[j])
		begin
			send(mops[j]);
			f = exp_flags(mops[j], f);
			chk({12'h0, trig_match_ff, auto_reject_ff, keep_token_ff, trig_sub_ff}, {12'h0, f});
			send(8'h02);
			tah_host_bfm_inst.rd(r);
			chk(r, {15'h0, f[3]});
		end
		// Two rounds of boundary values, then random ones
		for (int k = 0; k < 4; k++)
		begin
			d = (k == 0) ? 64'hF001F800FFFF0000 : (k == 1) ? 64'h0FFF002800320001
				: {4'($urandom), 12'($urandom_range(4095, 1)), 16'(int'($urandom_range(2088)) - 2048),
				16'($urandom), 16'($urandom)};
			for (int i = 0; i < 4; i++)
			begin
				send(8'h10 + 8'(i));
				chk({15'h0, cmd_busy}, 16'h0001);
				tah_host_bfm_inst.wr(d[63 - 16 * i -: 16]);
				cfg[i] = exp_word(i, d[63 - 16 * i -: 16]);
			end
			cfg_chk;
			send(k[0] ? 8'h14 : 8'h15);
			send(8'h16);
			for (int i = 0; i < 5; i++)
			begin
				tah_host_bfm_inst.rd(r);
				chk(r, (i < 4) ? cfg[i] : {15'h0, k[0]});
			end
			chk({15'h0, cmd_busy}, 16'h0000);
		end
		u = cfg;
		send(8'h06);
		repeat (50) @(negedge core_clk);
		send(8'h10);
		tah_host_bfm_inst.wr(16'h0123);
		send(8'h07);
		cfg_chk;
		chk({15'h0, trig_match_ff}, 16'h0001);
		send(8'h05);
		cfg = dflt;
		cfg_chk;
		chk({15'h0, trig_match_ff}, 16'h0000);
		send(8'h08);
		repeat (50) @(negedge core_clk);
		do_reset;
		cfg = u;
		cfg_chk;
		send(8'h09);
		repeat (50) @(negedge core_clk);
		do_reset;
		cfg = dflt;
		cfg_chk;
		for (int n = 0; n < NC; n++)
		begin
			tah_host_bfm_inst.wr({8'h74, 8'(n)});
			tah_host_bfm_inst.rd(r);
			chk(r, {5'h0, conv_err_bits[n * 11 +: 11]});
		end
		tah_host_bfm_inst.wr(16'hC902);
		d = 64'h0;
		for (int w = 0; w < 41; w++)
		begin
			tah_host_bfm_inst.rd(r);
			chk(r, 16'({10'h0, conv_chain_bits[2 * 646 +: 646]} >> (16 * w)));
		end
		chk({15'h0, cmd_busy}, 16'h0000);
		give_verdict;
	end
	// Hang guard, well beyond the 1800 or so cycles the sequence needs
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		give_verdict;
	end
endmodule // tb
